// ==== chan_backend_defines.svh ====
// Constants for the channel back-end filter pair
`ifndef CHAN_BACKEND_DEFINES_SVH
`define CHAN_BACKEND_DEFINES_SVH
`define DATA_W      20
`define HCOEF_W     6
`define DCOEF_W     14
`define HTAPS_MAX   8
`define DRAM_DEPTH  64
`define DHIST_DEPTH 128
`define SRC_CH      6
`define HCOEF_FRAC  5'h05
`define DCOEF_FRAC  5'h0D
`define ACC_W       48
`endif

// ==== chan_backend_pkg.sv ====
// Types shared by the channel back-end filter pair
`default_nettype none
`include "chan_backend_defines.svh"
package chan_backend_pkg;
  typedef struct packed {
    logic signed [`DATA_W-1:0] i;
    logic signed [`DATA_W-1:0] q;
  } iq_s;
  typedef enum logic [1:0] {H_IDLE, H_MAC} hstate_e;
  typedef enum logic [1:0] {D_IDLE, D_MAC, D_PUSH} dstate_e;
endpackage
`default_nettype wire

// ==== chan_backend.sv ====
// Helper FIR and decimating RAM FIR for one receive channel
`timescale 1ns/1ns
`default_nettype none
`include "chan_backend_defines.svh"
// Operation
// - Helper: nondecimating FIR, eight taps, 6-bit coefficients
// - Helper tap count field holds taps minus one
// - Helper 20-bit data, eight coefficient registers
// - Helper symmetry mirrors half response, eight taps max
// - Helper may run at half processing clock
// - Helper rate follows incoming second half-band samples
// - Helper bypass passes input unchanged
// - Helper 2-bit scale: 18, 12, 6, 0 dB
// - Decimator: 64 asymmetric, 128 symmetric taps
// - Decimation 1 to 16, field holds rate minus one
// - Decimator 20-bit data, 14-bit coefficients
// - Decimator tap count register holds taps minus one
// - Decimator bypass forwards input, no scaling
// - Decimator 2-bit scale: 18, 12, 6, 0 dB
// - Decimator symmetry mirrors stored half response
// - Offset change takes effect next output sample
// - Decimation phase selects output phase
// - One tap per clock per I and Q
// - Coefficient access steps address start to stop
// - Byte mode: low byte first, commit on high
// - Data select picks front-end channel zero to five
module chan_backend
  import chan_backend_pkg::*;
(
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          CE,
  input  wire iq_s [`SRC_CH-1:0]             SRC_DATA,
  input  wire logic [`SRC_CH-1:0]            SRC_VALID,
  input  wire logic [2:0]                    DATA_SEL,
  input  wire logic [`HTAPS_MAX-1:0][`HCOEF_W-1:0] H_COEF,
  input  wire logic [2:0]                    H_TAPS,
  input  wire logic                          H_SYM,
  input  wire logic                          H_HALFCLK,
  input  wire logic                          H_BYPASS,
  input  wire logic [1:0]                    H_SCALE,
  input  wire logic [6:0]                    D_TAPS,
  input  wire logic [3:0]                    D_RATE,
  input  wire logic [3:0]                    D_PHASE,
  input  wire logic                          D_SYM,
  input  wire logic                          D_BYPASS,
  input  wire logic [1:0]                    D_SCALE,
  input  wire logic [5:0]                    D_OFFSET,
  input  wire logic [5:0]                    D_START,
  input  wire logic [5:0]                    D_STOP,
  input  wire logic                          CM_LOAD,
  input  wire logic                          CM_WR,
  input  wire logic                          CM_RD,
  input  wire logic                          CM_WIDE,
  input  wire logic [`DCOEF_W-1:0]           CM_WDATA,
  output logic      [`DCOEF_W-1:0]           CM_RDATA,
  output logic                               IN_READY,
  output iq_s                                OUT_DATA,
  output logic                               OUT_VALID,
  input  wire logic                          OUT_READY
);

  function automatic logic [2:0] src_idx(input logic [2:0] s);
    src_idx = s[2] ? (s[0] ? 3'h5 : 3'h4) : {1'b0, s[1:0]};
  endfunction

  function automatic logic [6:0] mirror(input logic [6:0] k,
                                        input logic [6:0] n,
                                        input logic       sym);
    mirror = (sym && (k > n - k)) ? n - k : k;
  endfunction

  // Scale 11 is unity; each step down is a further 6.02 dB
  function automatic logic signed [`DATA_W-1:0] scale_sat(
      input logic signed [`ACC_W-1:0] a, input logic [4:0] frac,
      input logic [1:0] sel);
    logic signed [`ACC_W-1:0] t;
    t = a >>> (frac + 5'(2'h3 - sel));
    if (t > `ACC_W'sh7FFFF) scale_sat = 20'sh7FFFF;
    else if (t < -`ACC_W'sh80000) scale_sat = -20'sh80000;
    else scale_sat = t[`DATA_W-1:0];
  endfunction

  iq_s                           src;
  logic                          src_vld;
  logic                          take;
  assign src     = SRC_DATA[src_idx(DATA_SEL)];
  assign src_vld = SRC_VALID[src_idx(DATA_SEL)];
  assign take    = CE && IN_READY && src_vld;

  // Helper filter
  iq_s     hhist_q [`HTAPS_MAX];
  hstate_e hst_q;
  logic [2:0] hk_q;
  logic    ph_q;
  logic    htick;
  logic signed [`ACC_W-1:0] hacc_i_q, hacc_q_q, hacc_i_d, hacc_q_d;
  logic signed [`HCOEF_W-1:0] hc;
  iq_s     hx;
  iq_s     h_out_q;
  logic    h_vld_q;

  assign htick = !H_HALFCLK || ph_q;
  assign hc = H_COEF[mirror({4'h0, hk_q}, {4'h0, H_TAPS}, H_SYM)];
  assign hx = hhist_q[hk_q];
  assign hacc_i_d = hacc_i_q + `ACC_W'(hx.i * hc);
  assign hacc_q_d = hacc_q_q + `ACC_W'(hx.q * hc);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) ph_q <= 1'b0;
    else if (CE) ph_q <= !ph_q;
  end

  always_ff @(posedge CLK) begin
    if (take) begin
      hhist_q[0] <= src;
      for (int j = 1; j < `HTAPS_MAX; j++) hhist_q[j] <= hhist_q[j-1];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hst_q    <= H_IDLE;
      hk_q     <= 3'h0;
      hacc_i_q <= '0;
      hacc_q_q <= '0;
      h_out_q  <= '0;
      h_vld_q  <= 1'b0;
    end else if (CE) begin
      h_vld_q <= 1'b0;
      unique case (hst_q)
        H_IDLE: if (take) begin
          if (H_BYPASS) begin
            h_out_q <= src;
            h_vld_q <= 1'b1;
          end else begin
            hst_q    <= H_MAC;
            hk_q     <= 3'h0;
            hacc_i_q <= '0;
            hacc_q_q <= '0;
          end
        end
        H_MAC: if (htick) begin
          hacc_i_q <= hacc_i_d;
          hacc_q_q <= hacc_q_d;
          hk_q     <= hk_q + 3'h1;
          if (hk_q == H_TAPS) begin
            hst_q     <= H_IDLE;
            h_vld_q   <= 1'b1;
            h_out_q.i <= scale_sat(hacc_i_d, `HCOEF_FRAC, H_SCALE);
            h_out_q.q <= scale_sat(hacc_q_d, `HCOEF_FRAC, H_SCALE);
          end
        end
      endcase
    end
  end

  // Decimating filter
  logic [`DCOEF_W-1:0] cram [`DRAM_DEPTH];
  iq_s     dhist [`DHIST_DEPTH];
  logic [6:0] dwp_q, base_q, dk_q, dn_q;
  logic [3:0] dcnt_q;
  logic [5:0] off_q;
  logic    dsym_q;
  dstate_e dst_q;
  logic signed [`ACC_W-1:0] dacc_i_q, dacc_q_q, dacc_i_d, dacc_q_d;
  logic signed [`DCOEF_W-1:0] dc;
  iq_s     dx;
  iq_s     res_q;
  logic    dstart;
  logic    push;
  iq_s     push_data;
  logic [1:0] cnt_q, cnt_d;
  logic    pop;

  assign dstart = h_vld_q && !D_BYPASS && dcnt_q == D_PHASE && dst_q == D_IDLE;
  assign dc = cram[6'(off_q + 6'(mirror(dk_q, dn_q, dsym_q)))];
  assign dx = dhist[7'(base_q - dk_q)];
  assign dacc_i_d = dacc_i_q + `ACC_W'(dx.i * dc);
  assign dacc_q_d = dacc_q_q + `ACC_W'(dx.q * dc);

  always_ff @(posedge CLK) begin
    if (CE && h_vld_q) dhist[dwp_q] <= h_out_q;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dwp_q  <= 7'h00;
      dcnt_q <= 4'h0;
    end else if (CE && h_vld_q) begin
      dwp_q  <= dwp_q + 7'h01;
      dcnt_q <= (dcnt_q == D_RATE) ? 4'h0 : dcnt_q + 4'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dst_q    <= D_IDLE;
      dk_q     <= 7'h00;
      dn_q     <= 7'h00;
      base_q   <= 7'h00;
      off_q    <= 6'h00;
      dsym_q   <= 1'b0;
      dacc_i_q <= '0;
      dacc_q_q <= '0;
      res_q    <= '0;
    end else if (CE) begin
      unique case (dst_q)
        D_IDLE: if (dstart) begin
          dst_q    <= D_MAC;
          base_q   <= dwp_q;
          dk_q     <= 7'h00;
          dn_q     <= D_TAPS;
          off_q    <= D_OFFSET;
          dsym_q   <= D_SYM;
          dacc_i_q <= '0;
          dacc_q_q <= '0;
        end
        D_MAC: begin
          dacc_i_q <= dacc_i_d;
          dacc_q_q <= dacc_q_d;
          dk_q     <= dk_q + 7'h01;
          if (dk_q == dn_q) begin
            dst_q   <= D_PUSH;
            res_q.i <= scale_sat(dacc_i_d, `DCOEF_FRAC, D_SCALE);
            res_q.q <= scale_sat(dacc_q_d, `DCOEF_FRAC, D_SCALE);
          end
        end
        D_PUSH: if (push) dst_q <= D_IDLE;
        default: dst_q <= D_IDLE;
      endcase
    end
  end

  // Coefficient access port
  logic [5:0] cptr_q;
  logic       byte_q;
  logic [7:0] lo_q;
  logic       commit;
  assign commit = CE && CM_WR && !CM_LOAD && (CM_WIDE || byte_q);

  always_ff @(posedge CLK) begin
    if (commit)
      cram[cptr_q] <= CM_WIDE ? CM_WDATA : {CM_WDATA[5:0], lo_q};
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cptr_q   <= 6'h00;
      byte_q   <= 1'b0;
      lo_q     <= 8'h00;
      CM_RDATA <= '0;
    end else if (CE) begin
      if (CM_LOAD) begin
        cptr_q <= D_START;
        byte_q <= 1'b0;
      end else begin
        if (CM_WR && !CM_WIDE) begin
          byte_q <= !byte_q;
          if (!byte_q) lo_q <= CM_WDATA[7:0];
        end
        if (CM_RD) CM_RDATA <= cram[cptr_q];
        if (commit || CM_RD)
          cptr_q <= (cptr_q == D_STOP) ? D_START : cptr_q + 6'h01;
      end
    end
  end

  // Two-entry output buffer; no word is dropped when the sink stalls
  iq_s tail_q;
  assign pop       = OUT_VALID && OUT_READY;
  assign push      = CE && (D_BYPASS ? h_vld_q : (dst_q == D_PUSH)) &&
                     (cnt_q != 2'h2 || pop);
  assign push_data = D_BYPASS ? h_out_q : res_q;
  assign cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop && CE};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_q     <= 2'h0;
      OUT_DATA  <= '0;
      tail_q    <= '0;
      OUT_VALID <= 1'b0;
      IN_READY  <= 1'b0;
    end else if (CE) begin
      cnt_q     <= cnt_d;
      OUT_VALID <= cnt_d != 2'h0;
      if (pop) OUT_DATA <= (cnt_q == 2'h2) ? tail_q : push_data;
      else if (push && cnt_q == 2'h0) OUT_DATA <= push_data;
      if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2 && pop)))
        tail_q <= push_data;
      // One result in flight at most, so the buffer always has room
      IN_READY <= hst_q == H_IDLE && !take && !h_vld_q &&
                  dst_q == D_IDLE && cnt_d != 2'h2;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST || !CE);

  AST_H_BYPASS: assert property (take && H_BYPASS |=>
    h_vld_q && h_out_q == $past(src)) else $error("helper bypass");
  AST_H_STROBE: assert property (h_vld_q |=> !h_vld_q)
    else $error("helper strobe longer than one cycle");
  AST_H_LEN: assert property (take && !H_BYPASS && !H_HALFCLK &&
    H_TAPS == 3'h1 |-> ##3 h_vld_q) else $error("helper tap count");
  AST_H_HALF: assert property (take && !H_BYPASS && H_HALFCLK &&
    H_TAPS == 3'h0 |-> !h_vld_q ##1 ##[1:2] h_vld_q)
    else $error("helper half rate");
  AST_D_RATE: assert property (h_vld_q && dcnt_q == D_RATE |=>
    dcnt_q == 4'h0) else $error("decimation counter wrap");
  AST_D_PHASE: assert property (dstart |=> dst_q == D_MAC &&
    dk_q == 7'h00) else $error("phase start missed");
  AST_D_OFF: assert property (dst_q == D_MAC && $past(dst_q) == D_MAC
    |-> $stable(off_q)) else $error("offset changed mid sample");
  AST_D_LATCH: assert property (dstart |=> off_q == $past(D_OFFSET) &&
    dn_q == $past(D_TAPS)) else $error("offset not latched at start");
  AST_D_LEN: assert property (dst_q == D_MAC && dk_q == dn_q |=>
    dst_q == D_PUSH) else $error("decimator tap count");
  AST_CPTR: assert property (commit && !CM_LOAD && cptr_q == D_STOP
    |=> cptr_q == $past(D_START)) else $error("address wrap");
  AST_BYTE: assert property (CM_WR && !CM_WIDE && !byte_q && !CM_LOAD
    && !CM_RD |=> byte_q && $stable(cptr_q)) else $error("low byte commit");
  AST_D_BYP: assert property (D_BYPASS && $stable(D_BYPASS) &&
    push && cnt_q == 2'h0 |=> OUT_DATA == $past(h_out_q))
    else $error("decimator bypass altered data");
  AST_HOLD: assert property (OUT_VALID && !OUT_READY |=>
    OUT_VALID && $stable(OUT_DATA)) else $error("output not held");

  COV_FULL: cover property (cnt_q == 2'h2);
  COV_DEC: cover property (dst_q == D_PUSH && push && D_RATE == 4'hF);
  COV_SYM: cover property (dst_q == D_MAC && dsym_q && dk_q == dn_q);

endmodule
`default_nettype wire

// ==== far_ends.sv ====
// Far-side model: half-band sample source and stalling output sink
`timescale 1ns/1ns
`default_nettype none
module far_ends
  import chan_backend_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               OFFER,
  input  wire logic signed [19:0] SMP,
  input  wire logic               STALL,
  input  wire iq_s                OUT_DATA,
  input  wire logic               OUT_VALID,
  output var  iq_s [5:0]          SRC_DATA,
  output logic [5:0]              SRC_VALID,
  output logic                    OUT_READY
);
  iq_s                got[$];
  logic signed [19:0] junk = 20'h00000;

  // Idle lines churn so a stale sample can never pass as fresh
  always_ff @(posedge CLK) begin
    junk <= junk + 20'h13579;
  end

  // While OFFER is high each channel carries a distinct value; q is the exact negative
  always_comb begin
    for (int c = 0; c < 6; c++) begin
      SRC_DATA[c].i = OFFER ? SMP + 20'(c * 4096) : junk;
      SRC_DATA[c].q = OFFER ? -(SMP + 20'(c * 4096)) : ~junk;
    end
  end
  assign SRC_VALID = {6{OFFER}};
  assign OUT_READY = !STALL;

  always @(posedge CLK) begin
    if (OUT_VALID && OUT_READY) begin
      got.push_back(OUT_DATA);
    end
  end
endmodule
`default_nettype wire

// ==== chan_backend_test.sv ====
// Self-checking bench for the channel back-end filter pair
`timescale 1ns/1ns
`default_nettype none
module chan_backend_test;
  import chan_backend_pkg::*;
  logic               clk = 1'b0, rst = 1'b1, offer = 1'b0, stall = 1'b0;
  logic signed [19:0] smp = 20'h00000;
  logic [2:0]         sel = 3'h0, h_taps = 3'h0;
  logic [7:0][5:0]    h_coef = '0;
  logic               h_sym = 1'b0, h_half = 1'b0, h_byp = 1'b1;
  logic               d_sym = 1'b0, d_byp = 1'b1, cm_ld = 1'b0;
  logic               cm_wr = 1'b0, cm_rd = 1'b0, cm_wide = 1'b1;
  logic [1:0]         h_scale = 2'h0, d_scale = 2'h0;
  logic [6:0]         d_taps = 7'h00;
  logic [3:0]         d_rate = 4'h0, d_phase = 4'h0;
  logic [5:0]         d_off = 6'h00, d_start = 6'h00, d_stop = 6'h00;
  logic [13:0]        cm_wdata = 14'h0000, cm_rdata;
  logic               in_ready, out_valid, out_ready;
  logic [5:0]         src_valid;
  iq_s [5:0]          src_data;
  iq_s                out_data;
  int                 miscompares = 0, checks_done = 0;
  logic               ce = 1'b1;

  always #50 clk = ~clk;

  chan_backend uut (
    .CLK(clk), .RST(rst), .CE(ce), .SRC_DATA(src_data),
    .SRC_VALID(src_valid), .DATA_SEL(sel), .H_COEF(h_coef),
    .H_TAPS(h_taps), .H_SYM(h_sym), .H_HALFCLK(h_half),
    .H_BYPASS(h_byp), .H_SCALE(h_scale), .D_TAPS(d_taps),
    .D_RATE(d_rate), .D_PHASE(d_phase), .D_SYM(d_sym),
    .D_BYPASS(d_byp), .D_SCALE(d_scale), .D_OFFSET(d_off),
    .D_START(d_start), .D_STOP(d_stop), .CM_LOAD(cm_ld),
    .CM_WR(cm_wr), .CM_RD(cm_rd), .CM_WIDE(cm_wide),
    .CM_WDATA(cm_wdata), .CM_RDATA(cm_rdata), .IN_READY(in_ready),
    .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready)
  );
  far_ends far (
    .CLK(clk), .OFFER(offer), .SMP(smp), .STALL(stall),
    .OUT_DATA(out_data), .OUT_VALID(out_valid), .SRC_DATA(src_data),
    .SRC_VALID(src_valid), .OUT_READY(out_ready)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_d(input logic [19:0] g, input logic [19:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: data %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_c(input logic [13:0] g, input logic [13:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: coefficient %h expected %h", $time, g, e);
    end
  endtask

  // Sample is held until an edge sees ready high
  task automatic send(input logic signed [19:0] x);
    int n;
    n = 0;
    @(posedge clk);
    offer <= 1'b1;
    smp <= x;
    do begin
      @(negedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 400);
    if (in_ready !== 1'b1) begin
      miscompares++;
      $display("Error %0t: sample never taken", $time);
    end
    @(posedge clk);
    offer <= 1'b0;
  endtask

  task automatic cm(input logic ld, wr, rdn, input logic [13:0] d);
    @(posedge clk);
    cm_ld <= ld;
    cm_wr <= wr;
    cm_rd <= rdn;
    cm_wdata <= d;
    @(posedge clk);
    cm_ld <= 1'b0;
    cm_wr <= 1'b0;
    cm_rd <= 1'b0;
  endtask

  task automatic cm_read(input logic [13:0] e);
    cm(1'b0, 1'b0, 1'b1, 14'h0000);
    @(negedge clk);
    @(negedge clk);
    chk_c(cm_rdata, e);
  endtask

  // Only the newest word is judged; older ones hang on unreset history
  task automatic outs(input int n, input logic signed [19:0] e);
    repeat (40) @(negedge clk);
    chk_d(20'(far.got.size()), 20'(n));
    if (far.got.size() > 0) begin
      chk_d(far.got[$].i, e);
      chk_d(far.got[$].q, -e);
    end
    far.got.delete();
  endtask

  initial begin
    logic [13:0] dc[3];
    dc = '{14'h1000, 14'h0800, 14'h3000};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    d_start <= 6'h05;
    d_stop <= 6'h06;
    cm(1'b1, 1'b0, 1'b0, 14'h0000);
    for (int k = 1; k < 4; k++) cm(1'b0, 1'b1, 1'b0, 14'(k * 273));
    cm(1'b1, 1'b0, 1'b0, 14'h0000);
    ce <= 1'b0;
    cm_read(14'h0000);
    @(posedge clk);
    ce <= 1'b1;
    cm_read(14'h0333);
    cm_read(14'h0222);
    cm_read(14'h0333);
    @(posedge clk);
    d_start <= 6'h09;
    d_stop <= 6'h09;
    cm_wide <= 1'b0;
    cm(1'b1, 1'b0, 1'b0, 14'h0000);
    cm(1'b0, 1'b1, 1'b0, 14'h0034);
    cm(1'b0, 1'b1, 1'b0, 14'h002A);
    cm(1'b1, 1'b0, 1'b0, 14'h0000);
    cm_read(14'h2A34);
    @(posedge clk);
    d_start <= 6'h00;
    d_stop <= 6'h02;
    cm_wide <= 1'b1;
    cm(1'b1, 1'b0, 1'b0, 14'h0000);
    foreach (dc[k]) cm(1'b0, 1'b1, 1'b0, dc[k]);
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= 3'(s);
      send(20'h00040);
      outs(1, 20'(64 + 4096 * (s > 3 ? 4 + s % 2 : s)));
    end
    @(posedge clk);
    sel <= 3'h0;
    h_byp <= 1'b0;
    h_coef <= {30'h00000000, 6'h30, 6'h08, 6'h10};
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      h_scale <= 2'(s);
      send(20'h00200);
      outs(1, 20'(32 << s));
    end
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      h_taps <= 3'h2;
      h_sym <= (m < 2);
      h_half <= (m == 1);
      for (int k = 0; k < 3; k++) send(20'(64 << k));
      outs(3, m < 2 ? 20'd192 : 20'd128);
    end
    @(posedge clk);
    rst <= 1'b1;
    h_byp <= 1'b1;
    d_byp <= 1'b0;
    d_scale <= 2'h3;
    d_rate <= 4'h3;
    d_phase <= 4'h2;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int k = 1; k < 9; k++) send(20'(64 * k));
    outs(2, 20'd224);
    @(posedge clk);
    d_rate <= 4'h0;
    d_phase <= 4'h0;
    d_off <= 6'h01;
    d_scale <= 2'h2;
    send(20'h00100);
    outs(1, 20'd32);
    @(posedge clk);
    d_off <= 6'h00;
    d_scale <= 2'h3;
    d_sym <= 1'b1;
    d_taps <= 7'h02;
    for (int k = 0; k < 3; k++) send(20'(64 << k));
    outs(3, 20'd192);
    @(posedge clk);
    d_byp <= 1'b1;
    stall <= 1'b1;
    send(20'h00040);
    send(20'h00080);
    fork
      send(20'h000C0);
      begin
        repeat (20) @(negedge clk);
        chk_d(20'(in_ready), 20'h00000);
        @(posedge clk);
        stall <= 1'b0;
      end
    join
    repeat (40) @(negedge clk);
    chk_d(far.got[0].i, 20'h00040);
    outs(3, 20'h000C0);
    results();
  end

  initial begin
    #1000000;
    miscompares++;
    $display("Error %0t: run did not finish", $time);
    results();
  end
endmodule
`default_nettype wire
